// File: hw/ebc_pkg.sv
/*
  constants, field layout and carrier types of the external bus controller.
  assumes one 250 MHz clock and the plain register port of the core.
*/
package ebc_pkg;
  // ***********************************************************
  // widths and timing
  // ***********************************************************
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int REG_AW = 16;
  localparam int REG_DW = 8;
  localparam int WAIT_W = 2;
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int WATCHDOG_NS = 4096;
  localparam int WATCHDOG_CYCLES = WATCHDOG_NS / CLOCK_PERIOD_NS;
  // ***********************************************************
  // register map and memory control layout
  // ***********************************************************
  localparam logic [REG_AW-1:0] MEM_CTRL_OFFSET = 16'h3F01;
  localparam logic [REG_AW-1:0] IRQ_STATUS_OFFSET = 16'h3F10;
  localparam logic [REG_AW-1:0] IRQ_CLEAR_OFFSET = 16'h3F11;
  localparam logic [REG_AW-1:0] IRQ_ENABLE_OFFSET = 16'h3F12;
  localparam logic [REG_DW-1:0] MEM_CTRL_RESET = 8'hCB;
  localparam int EXT_WAIT_LSB = 6;
  localparam int HANDSHAKE_BIT = 5;
  localparam int IRQ_WE_BIT = 4;
  localparam int EXT_MEM_BIT = 3;
  localparam int SPECIAL_WAIT_LSB = 0;
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_GRANTED = 1;
  localparam int IRQ_RETURNED = 2;
  localparam int IRQ_W = 3;
  // ***********************************************************
  // address windows
  // ***********************************************************
  localparam logic [ADDR_W-1:0] SPECIAL_BASE = 24'h00_3F00;
  localparam logic [ADDR_W-1:0] SPECIAL_LAST = 24'h00_3FFF;
  localparam logic [ADDR_W-1:0] EXP_RAM_BASE = 24'h00_2F00;
  localparam logic [ADDR_W-1:0] EXP_RAM_LAST = 24'h00_3EFF;
  localparam logic [ADDR_W-1:0] EXP_ROM_BASE = 24'h02_0000;
  localparam logic [ADDR_W-1:0] EXP_ROM_LAST = 24'h03_FFFF;
  // ***********************************************************
  // carriers
  // ***********************************************************
  typedef struct packed {
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cpu_req_type;
  typedef struct packed {
    logic ready;
    logic timeout;
    logic [DATA_W-1:0] rdata;
  } cpu_rsp_type;
  typedef struct packed {
    logic sel;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } periph_type;
endpackage : ebc_pkg

// File: hw/sync_two_flop.sv
/*
  two flip-flop synchroniser for asynchronous pin levels.
  assumes the inputs are slow levels with no relation to the clock.
*/
`timescale 1ns/1ns
`default_nettype none
module sync_two_flop #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule : sync_two_flop
`default_nettype wire

// File: hw/cycle_counter.sv
/*
  loadable down counter that stops at zero.
  assumes load and count enable come from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module cycle_counter #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  input wire logic count_en_i,
  output logic expired_o
);
  logic [W-1:0] cnt_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else if (load_i) begin
      cnt_reg <= value_i;
    end else if (count_en_i && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end
  assign expired_o = (cnt_reg == '0);
endmodule : cycle_counter
`default_nettype wire

// File: hw/ext_bus_ctrl.sv
/*
  external expansion bus controller: routing, wait sequencing, handshake,
  watchdog timeout and bus arbitration with an outside master.
  assumes the core holds its request until ready and that the pins are
  asynchronous to CLOCK_I.
*/
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
module ext_bus_ctrl #(
  parameter int WATCHDOG_LIMIT = ebc_pkg::WATCHDOG_CYCLES
) (
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic [ebc_pkg::REG_AW-1:0] REG_ADDR_I,
  input wire logic [ebc_pkg::REG_DW-1:0] REG_WDATA_I,
  input wire logic REG_WE_I,
  input wire logic REG_RE_I,
  output logic [ebc_pkg::REG_DW-1:0] REG_RDATA_O,
  input wire ebc_pkg::cpu_req_type CPU_REQ_I,
  output ebc_pkg::cpu_rsp_type CPU_RSP_O,
  output ebc_pkg::periph_type PERIPH_O,
  input wire logic [7:0] PERIPH_RDATA_I,
  output logic [ebc_pkg::ADDR_W-1:0] EXT_ADDR_O,
  output logic EXT_ADDR_OE_O,
  output logic [ebc_pkg::DATA_W-1:0] EXT_DATA_O,
  input wire logic [ebc_pkg::DATA_W-1:0] EXT_DATA_I,
  output logic EXT_DATA_OE_O,
  output logic RD_STROBE_N_O,
  output logic WR_STROBE_N_O,
  input wire logic ACK_N_I,
  input wire logic MASTER_REQ_N_I,
  output logic MASTER_GRANT_N_O,
  input wire logic MEMORY_MODE_PIN_I,
  output logic SYSTEM_CLOCK_O,
  output logic IRQ_CTRL_WE_O,
  output logic NMI_O,
  output logic IRQ_O
);
  import ebc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_STROBE, ST_RECOVER, ST_RELEASE, ST_GRANTED
  } state_type;

  // ***********************************************************
  // pin synchronisers and clock enables
  // ***********************************************************
  logic ack_n_sync, req_n_sync, mode_pin_sync;
  logic osc_phase_reg, sys_phase_reg, req_sampled_n_reg;
  logic sample_en, osc_rise_en;

  sync_two_flop #(.W(3), .RESET_VAL(3'b110)) u_sync (
    .clk_i(CLOCK_I),
    .rst_n_i(RESET_N_I),
    .async_i({ACK_N_I, MASTER_REQ_N_I, MEMORY_MODE_PIN_I}),
    .sync_o({ack_n_sync, req_n_sync, mode_pin_sync})
  );

  // main oscillator at half, system clock at quarter of CLOCK_I
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      osc_phase_reg <= 1'b0;
      sys_phase_reg <= 1'b0;
    end else begin
      osc_phase_reg <= ~osc_phase_reg;
      if (osc_phase_reg) begin
        sys_phase_reg <= ~sys_phase_reg;
      end
    end
  end
  assign sample_en = osc_phase_reg && sys_phase_reg;
  assign osc_rise_en = ~osc_phase_reg;
  assign SYSTEM_CLOCK_O = sys_phase_reg;

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      req_sampled_n_reg <= 1'b1;
    end else if (sample_en) begin
      req_sampled_n_reg <= req_n_sync;
    end
  end

  // ***********************************************************
  // registers
  // ***********************************************************
  logic [REG_DW-1:0] mem_ctrl_reg;
  logic [IRQ_W-1:0] irq_status_reg, irq_enable_reg, irq_event;
  logic [WAIT_W-1:0] special_reg_wait_field, external_wait_field;
  logic handshake_sel, irq_ctrl_write_enable, external_memory_flag;
  logic proc_mode, exp_mode, wr_mem, wr_clr, wr_en;

  assign wr_mem = REG_WE_I && REG_ADDR_I == MEM_CTRL_OFFSET;
  assign wr_clr = REG_WE_I && REG_ADDR_I == IRQ_CLEAR_OFFSET;
  assign wr_en = REG_WE_I && REG_ADDR_I == IRQ_ENABLE_OFFSET;

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      mem_ctrl_reg <= MEM_CTRL_RESET;
    end else if (wr_mem) begin
      mem_ctrl_reg <= REG_WDATA_I;
    end
  end

  assign external_wait_field = mem_ctrl_reg[EXT_WAIT_LSB +: WAIT_W];
  assign special_reg_wait_field = mem_ctrl_reg[SPECIAL_WAIT_LSB +: WAIT_W];
  assign handshake_sel = mem_ctrl_reg[HANDSHAKE_BIT];
  assign irq_ctrl_write_enable = mem_ctrl_reg[IRQ_WE_BIT];
  assign external_memory_flag = mem_ctrl_reg[EXT_MEM_BIT];
  assign IRQ_CTRL_WE_O = irq_ctrl_write_enable;
  assign proc_mode = mode_pin_sync;
  assign exp_mode = ~mode_pin_sync && external_memory_flag;

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      irq_enable_reg <= '0;
    end else if (wr_en && irq_ctrl_write_enable) begin
      irq_enable_reg <= REG_WDATA_I[IRQ_W-1:0];
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg &
        ~(wr_clr ? REG_WDATA_I[IRQ_W-1:0] : '0)) | irq_event;
    end
  end
  assign IRQ_O = |(irq_status_reg & irq_enable_reg);

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O <= '0;
    end else if (REG_RE_I) begin
      case (REG_ADDR_I)
        MEM_CTRL_OFFSET: REG_RDATA_O <= mem_ctrl_reg;
        IRQ_STATUS_OFFSET: REG_RDATA_O <= REG_DW'(irq_status_reg);
        IRQ_ENABLE_OFFSET: REG_RDATA_O <= REG_DW'(irq_enable_reg);
        default: REG_RDATA_O <= '0;
      endcase
    end
  end

  // ***********************************************************
  // routing and sequencing
  // ***********************************************************
  state_type state_reg, state_next;
  logic in_special, in_exp, start, ext_cyc_reg, hs_cyc_reg, we_reg;
  logic wait_done, wdog_done, ack_seen, timeout_hit;
  logic [WAIT_W-1:0] cur_wait;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;

  assign in_special = CPU_REQ_I.addr >= SPECIAL_BASE &&
    CPU_REQ_I.addr <= SPECIAL_LAST;
  assign in_exp = (proc_mode || exp_mode) &&
    ((CPU_REQ_I.addr >= EXP_RAM_BASE && CPU_REQ_I.addr <= EXP_RAM_LAST) ||
     (CPU_REQ_I.addr >= EXP_ROM_BASE && CPU_REQ_I.addr <= EXP_ROM_LAST));
  assign start = state_reg == ST_IDLE && CPU_REQ_I.req &&
    req_sampled_n_reg && (in_special || in_exp);
  assign cur_wait = in_special ? special_reg_wait_field
    : external_wait_field;
  assign ack_seen = hs_cyc_reg && !ack_n_sync;
  assign timeout_hit = hs_cyc_reg && ack_n_sync && wdog_done;

  cycle_counter #(.W(WAIT_W)) u_wait (
    .clk_i(CLOCK_I),
    .rst_n_i(RESET_N_I),
    .load_i(start),
    .value_i(cur_wait),
    .count_en_i(state_reg == ST_STROBE),
    .expired_o(wait_done)
  );

  cycle_counter #(.W($clog2(WATCHDOG_LIMIT + 1))) u_wdog (
    .clk_i(CLOCK_I),
    .rst_n_i(RESET_N_I),
    .load_i(start),
    .value_i($clog2(WATCHDOG_LIMIT + 1)'(WATCHDOG_LIMIT)),
    .count_en_i(state_reg == ST_STROBE),
    .expired_o(wdog_done)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (!req_sampled_n_reg) begin
          state_next = ST_RELEASE;
        end else if (start) begin
          state_next = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (hs_cyc_reg ? (ack_seen || timeout_hit)
            : wait_done) begin
          state_next = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (!hs_cyc_reg || ack_n_sync) begin
          state_next = ST_IDLE;
        end
      end
      ST_RELEASE: state_next = ST_GRANTED;
      ST_GRANTED: begin
        if (req_sampled_n_reg && osc_rise_en) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ext_cyc_reg <= 1'b0;
      hs_cyc_reg <= 1'b0;
      we_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= '0;
    end else if (start) begin
      ext_cyc_reg <= !in_special;
      hs_cyc_reg <= !in_special && handshake_sel;
      we_reg <= CPU_REQ_I.we;
      addr_reg <= CPU_REQ_I.addr;
      wdata_reg <= CPU_REQ_I.wdata;
    end
  end

  // ***********************************************************
  // pins and responses
  // ***********************************************************
  logic strobing, ending;
  assign strobing = state_reg == ST_STROBE;
  assign ending = strobing && state_next == ST_RECOVER;

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      RD_STROBE_N_O <= 1'b1;
      WR_STROBE_N_O <= 1'b1;
      EXT_DATA_OE_O <= 1'b0;
      PERIPH_O <= '0;
    end else begin
      RD_STROBE_N_O <= !(state_next == ST_STROBE &&
        (start ? !in_special && !CPU_REQ_I.we : ext_cyc_reg && !we_reg));
      WR_STROBE_N_O <= !(state_next == ST_STROBE &&
        (start ? !in_special && CPU_REQ_I.we : ext_cyc_reg && we_reg));
      EXT_DATA_OE_O <= state_next == ST_STROBE &&
        (start ? !in_special && CPU_REQ_I.we : ext_cyc_reg && we_reg);
      PERIPH_O.sel <= state_next == ST_STROBE &&
        (start ? in_special : !ext_cyc_reg);
      PERIPH_O.we <= start ? CPU_REQ_I.we : PERIPH_O.we;
      PERIPH_O.addr <= start ? CPU_REQ_I.addr[7:0] : PERIPH_O.addr;
      PERIPH_O.wdata <= start ? CPU_REQ_I.wdata[7:0] : PERIPH_O.wdata;
    end
  end

  assign EXT_ADDR_O = addr_reg;
  assign EXT_DATA_O = wdata_reg;
  assign EXT_ADDR_OE_O = !(state_reg == ST_RELEASE ||
    state_reg == ST_GRANTED);

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      MASTER_GRANT_N_O <= 1'b1;
    end else begin
      MASTER_GRANT_N_O <= !(state_next == ST_GRANTED);
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      CPU_RSP_O <= '0;
      NMI_O <= 1'b0;
    end else begin
      CPU_RSP_O.ready <= ending;
      CPU_RSP_O.timeout <= ending && timeout_hit;
      NMI_O <= ending && timeout_hit;
      if (ending && !we_reg) begin
        CPU_RSP_O.rdata <= ext_cyc_reg ? EXT_DATA_I
          : DATA_W'(PERIPH_RDATA_I);
      end
    end
  end

  assign irq_event[IRQ_TIMEOUT] = ending && timeout_hit;
  assign irq_event[IRQ_GRANTED] = state_reg == ST_RELEASE;
  assign irq_event[IRQ_RETURNED] = state_reg == ST_GRANTED &&
    state_next == ST_IDLE;

  // ***********************************************************
  // checks
  // ***********************************************************
  logic [3:0] strobe_len_reg;
  logic [WAIT_W-1:0] wait_taken_reg;
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      strobe_len_reg <= '0;
      wait_taken_reg <= '0;
    end else begin
      strobe_len_reg <= strobing ? strobe_len_reg + 1'b1 : '0;
      if (start) begin
        wait_taken_reg <= cur_wait;
      end
    end
  end

  property p_fixed_len;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    ending && !hs_cyc_reg |-> strobe_len_reg == 4'(wait_taken_reg);
  endproperty
  a_fixed_len: assert property (p_fixed_len)
    else $error("fixed cycle length differs from wait count");

  property p_reset_wait;
    @(posedge CLOCK_I) $rose(RESET_N_I) |->
      external_wait_field == 2'h3 && special_reg_wait_field == 2'h3 &&
      !handshake_sel;
  endproperty
  a_reset_wait: assert property (p_reset_wait)
    else $error("reset does not select fixed three-wait sequencing");

  property p_special;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    start && in_special |=> wait_taken_reg == $past(special_reg_wait_field)
      && PERIPH_O.sel && RD_STROBE_N_O && WR_STROBE_N_O;
  endproperty
  a_special: assert property (p_special)
    else $error("special window cycle used wrong wait or bus");

  property p_hs_start;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    start && !in_special && !CPU_REQ_I.we |=> !RD_STROBE_N_O &&
      WR_STROBE_N_O;
  endproperty
  a_hs_start: assert property (p_hs_start)
    else $error("read cycle did not drive read strobe low");

  property p_ack_end;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    strobing && ack_seen |=> RD_STROBE_N_O && WR_STROBE_N_O &&
      CPU_RSP_O.ready;
  endproperty
  a_ack_end: assert property (p_ack_end)
    else $error("acknowledge did not end the handshake cycle");

  property p_ignore_ack;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    strobing && !hs_cyc_reg && !wait_done |=> state_reg == ST_STROBE;
  endproperty
  a_ignore_ack: assert property (p_ignore_ack)
    else $error("fixed cycle ended before its wait count");

  property p_nmi;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    $rose(NMI_O) |-> $past(hs_cyc_reg) && $past(ack_n_sync) &&
      CPU_RSP_O.timeout ##1 !NMI_O;
  endproperty
  a_nmi: assert property (p_nmi)
    else $error("timeout interrupt without a missing acknowledge");

  property p_float_grant;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    $fell(MASTER_GRANT_N_O) |-> !EXT_ADDR_OE_O && !EXT_DATA_OE_O &&
      $past(state_reg) == ST_RELEASE;
  endproperty
  a_float_grant: assert property (p_float_grant)
    else $error("grant given before the bus was floated");

  property p_return;
    @(posedge CLOCK_I) disable iff (!RESET_N_I)
    state_reg == ST_GRANTED && req_sampled_n_reg ##0 osc_rise_en |=>
      MASTER_GRANT_N_O ##1 EXT_ADDR_OE_O;
  endproperty
  a_return: assert property (p_return)
    else $error("grant not returned at oscillator rise");
endmodule : ext_bus_ctrl
`default_nettype wire

// File: verification/ext_device_model.sv
/*
  external memory or i/o device on the expansion bus, with a
  programmable acknowledge delay and a silent mode.
  assumes the controller's strobes and clock.
*/
`timescale 1ns/1ns
`default_nettype none
module ext_device_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [ebc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ebc_pkg::DATA_W-1:0] wdata_i,
  input wire logic [3:0] delay_i,
  input wire logic mute_i,
  output logic [ebc_pkg::DATA_W-1:0] rdata_o,
  output logic ack_n_o
);
  import ebc_pkg::*;
  logic [DATA_W-1:0] mem_reg [16];
  logic [7:0] wait_reg;
  // ****************
  // acknowledge
  // ****************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_n_o <= 1'b1;
      wait_reg <= 8'h00;
    end else if (rd_n_i && wr_n_i) begin
      ack_n_o <= 1'b1;
      wait_reg <= 8'h00;
    end else begin
      wait_reg <= wait_reg + 8'h01;
      if (!mute_i && wait_reg >= {4'h0, delay_i}) begin
        ack_n_o <= 1'b0;
      end
    end
  end
  // ****************
  // storage
  // ****************
  always_ff @(posedge clk_i) begin
    if (!wr_n_i) begin
      mem_reg[addr_i[3:0]] <= wdata_i;
    end
  end
  // undriven data lines show the inverse
  assign rdata_o = rd_n_i ? ~mem_reg[addr_i[3:0]] : mem_reg[addr_i[3:0]];
endmodule : ext_device_model
`default_nettype wire

// File: verification/external_bus_controller_bench.sv
/*
  self-checking bench of the external bus controller.
  assumes the device model on the expansion pins.
*/
`timescale 1ns/1ns
`default_nettype none
module external_bus_controller_bench;
  import ebc_pkg::*;
  typedef struct packed {
    logic [7:0] len;
    logic to;
    logic [15:0] rdata;
    logic [15:0] mask;
  } exp_type;
  logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0, mode = 1'b0;
  logic mreq_n = 1'b1, mute = 1'b0, rseen = 1'b0, seen;
  logic rd_n, wr_n, ack_n, grant_n, aoe, doe, sclk, irq_we, nmi, irq;
  logic [15:0] addr = '0, d, din, dout;
  logic [7:0] wdata = '0, rdata, prd = '0, p;
  logic [23:0] eaddr, a;
  logic [3:0] dly = '0;
  cpu_req_type req = '0;
  cpu_rsp_type rsp;
  periph_type per;
  exp_type eq[$];
  logic [7:0] rq[$];
  int fails = 0, cmp_count = 0, lo = 0, hi = 0;
  always #2 clk = ~clk;
  ext_bus_ctrl #(.WATCHDOG_LIMIT(16)) dut_u (
    .CLOCK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WE_I(we), .REG_RE_I(re),
    .REG_RDATA_O(rdata), .CPU_REQ_I(req), .CPU_RSP_O(rsp),
    .PERIPH_O(per), .PERIPH_RDATA_I(prd), .EXT_ADDR_O(eaddr),
    .EXT_ADDR_OE_O(aoe), .EXT_DATA_O(dout), .EXT_DATA_I(din),
    .EXT_DATA_OE_O(doe), .RD_STROBE_N_O(rd_n), .WR_STROBE_N_O(wr_n),
    .ACK_N_I(ack_n), .MASTER_REQ_N_I(mreq_n),
    .MASTER_GRANT_N_O(grant_n), .MEMORY_MODE_PIN_I(mode),
    .SYSTEM_CLOCK_O(sclk), .IRQ_CTRL_WE_O(irq_we), .NMI_O(nmi),
    .IRQ_O(irq)
  );
  ext_device_model dev_u (
    .clk_i(clk), .rst_n_i(rst_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .addr_i(eaddr), .wdata_i(dout), .delay_i(dly), .mute_i(mute),
    .rdata_o(din), .ack_n_o(ack_n)
  );
  // ****************
  // tasks
  // ****************
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("ERROR %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic reg_wr(input logic [15:0] ra, input logic [7:0] rd);
    @(posedge clk);
    addr <= ra;
    wdata <= rd;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [15:0] ra, input logic [7:0] e);
    rq.push_back(e);
    @(posedge clk);
    addr <= ra;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
  endtask : reg_rd
  task automatic cpu_op(input logic w, input logic [23:0] ca,
      input logic [15:0] cd, input exp_type e);
    int n;
    eq.push_back(e);
    @(posedge clk);
    req <= '{1'b1, w, ca, cd};
    for (n = 0; n < 300; n++) begin
      @(posedge clk);
      if (rsp.ready === 1'b1) break;
    end
    req.req <= 1'b0;
    if (n == 300) begin
      fails++;
      finish_test();
    end
  endtask : cpu_op
  task automatic wait_grant(input logic lvl);
    int n;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (grant_n === lvl) break;
    end
    if (n == 64) begin
      fails++;
      finish_test();
    end
  endtask : wait_grant
  // ****************
  // result monitor
  // ****************
  always @(negedge clk) begin
    exp_type e;
    if (!rd_n || !wr_n || per.sel) lo++;
    if (!wr_n) check(32'(doe), 32'h1);
    if (per.sel === 1'b1) check(32'({per.we, per.addr}), 32'h020);
    if (rseen) check(32'(rdata), 32'(rq.pop_front()));
    rseen = re;
    if (rsp.ready === 1'b1) begin
      e = eq.pop_front();
      if (e.len != 8'h00) check(32'(lo), 32'(e.len));
      check(32'({rsp.timeout, nmi}), 32'({2{e.to}}));
      check(32'(rsp.rdata & e.mask), 32'(e.rdata & e.mask));
      lo = 0;
    end
    if (grant_n === 1'b0) check(32'({rd_n, wr_n, aoe, doe}), 32'hC);
  end
  // ****************
  // sequence
  // ****************
  initial begin
    void'($urandom(32'h83f4));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    reg_rd(MEM_CTRL_OFFSET, MEM_CTRL_RESET);
    reg_rd(16'h3F20, 8'h00);
    reg_rd(IRQ_CLEAR_OFFSET, 8'h00);
    d = 16'($urandom);
    cpu_op(1'b1, EXP_RAM_BASE, d, '{8'h04, 1'b0, 16'h0, 16'h0});
    cpu_op(1'b0, EXP_RAM_BASE, 16'h0, '{8'h04, 1'b0, d, 16'hFFFF});
    $display("test reset defaults done");
    for (int w = 0; w < 4; w++) begin
      reg_wr(MEM_CTRL_OFFSET, {2'(w), 6'h08});
      d = 16'($urandom);
      a = w[0] ? EXP_ROM_LAST - 24'(w) : EXP_RAM_LAST - 24'(w);
      cpu_op(1'b1, a, d, '{8'(w + 1), 1'b0, 16'h0, 16'h0});
      cpu_op(1'b0, a, 16'h0, '{8'(w + 1), 1'b0, d, 16'hFFFF});
    end
    for (int s = 0; s < 4; s += 2) begin
      reg_wr(MEM_CTRL_OFFSET, {6'h32, 2'(s)});
      p = 8'($urandom);
      prd <= p;
      cpu_op(1'b0, SPECIAL_BASE + 24'h20, 16'h0,
             '{8'(s + 1), 1'b0, {8'h00, p}, 16'h00FF});
    end
    $display("test fixed waits done");
    reg_wr(MEM_CTRL_OFFSET, 8'h28);
    for (int k = 0; k < 2; k++) begin
      dly <= 4'(k * 7);
      d = 16'($urandom);
      cpu_op(1'b1, EXP_ROM_BASE + 24'h05, d, '0);
      cpu_op(1'b0, EXP_ROM_BASE + 24'h05, 16'h0,
             '{8'h00, 1'b0, d, 16'hFFFF});
    end
    $display("test handshake done");
    reg_wr(IRQ_CLEAR_OFFSET, 8'h07);
    reg_wr(IRQ_ENABLE_OFFSET, 8'h01);
    reg_rd(IRQ_ENABLE_OFFSET, 8'h00);
    mute <= 1'b1;
    cpu_op(1'b0, EXP_ROM_BASE, 16'h0, '{8'h00, 1'b1, 16'h0, 16'h0});
    mute <= 1'b0;
    reg_rd(IRQ_STATUS_OFFSET, 8'h01);
    reg_wr(MEM_CTRL_OFFSET, 8'h38);
    @(negedge clk);
    check(32'({irq, irq_we}), 32'h1);
    reg_wr(IRQ_ENABLE_OFFSET, 8'h01);
    reg_wr(IRQ_STATUS_OFFSET, 8'h00);
    @(negedge clk);
    check(32'(irq), 32'h1);
    reg_rd(IRQ_STATUS_OFFSET, 8'h01);
    reg_wr(IRQ_CLEAR_OFFSET, 8'h01);
    @(negedge clk);
    check(32'(irq), 32'h0);
    reg_wr(IRQ_ENABLE_OFFSET, 8'h00);
    reg_wr(MEM_CTRL_OFFSET, 8'h28);
    $display("test timeout and interrupts done");
    dly <= 4'h9;
    fork
      cpu_op(1'b1, EXP_ROM_BASE, 16'h1234, '0);
      begin
        repeat (3) @(posedge clk);
        mreq_n <= 1'b0;
      end
    join
    wait_grant(1'b0);
    mreq_n <= 1'b1;
    wait_grant(1'b1);
    @(negedge clk);
    check(32'(aoe), 32'h1);
    reg_rd(IRQ_STATUS_OFFSET, 8'h06);
    $display("test arbitration done");
    reg_wr(MEM_CTRL_OFFSET, 8'hC0);
    seen = 1'b0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, EXP_RAM_BASE, 16'h0};
    repeat (20) begin
      @(posedge clk);
      seen = seen | rsp.ready | !rd_n;
      if (sclk === 1'b1) hi++;
    end
    req.req <= 1'b0;
    check(32'(seen), 32'h0);
    check(32'(hi), 32'd10);
    mode <= 1'b1;
    repeat (4) @(posedge clk);
    cpu_op(1'b1, EXP_RAM_BASE, 16'hA5A5, '{8'h04, 1'b0, 16'h0, 16'h0});
    $display("test memory modes done");
    finish_test();
  end
endmodule : external_bus_controller_bench
`default_nettype wire
